// File: hbf_checker.sv
// Purpose: port-level checks of the half-bridge fault control
// Assumes: one mclk domain, synchronous active-low reset
// Notes:   no under-load timing check here, the bench covers it
`timescale 1ns/1ps
module hbf_checker
  import hbf_pkg::*;
#(
  parameter int unsigned UL_DELAY = 8
) (
  input  wire logic                     mclk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     enable_in,
  input  wire logic                     chip_select_n_in,
  input  wire logic                     sclk_in,
  input  wire logic                     sdi_in,
  input  wire logic                     sdo_out,
  input  wire logic                     sdo_oe_out,
  input  wire hbf_pkg::hbf_sense_t      sense_in,
  input  wire logic [hbf_pkg::CHANNELS-1:0] low_side_output_out,
  input  wire logic [hbf_pkg::CHANNELS-1:0] high_side_output_out,
  input  wire hbf_pkg::hbf_ctl_t        ctl_out,
  input  wire hbf_pkg::hbf_stat_t       status_out
);
  logic [SWITCHES-1:0] drv;

  always_comb
    for (int i = 0; i < CHANNELS; i++)
    begin
      drv[2*i]   = low_side_output_out[i];
      drv[2*i+1] = high_side_output_out[i];
    end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // pin syncs take two cycles, so idle must last three
  sequence cs_idle;
    chip_select_n_in [*3];
  endsequence
  sequence asleep;
    !enable_in [*4];
  endsequence

  chk_idle_tristate: assert property (cs_idle |-> !sdo_oe_out)
    else $error("serial out driven while deselected");
  chk_sleep_wipes: assert property (asleep |=> ctl_out == CTL_RST && drv == '0)
    else $error("state kept in sleep");
  chk_hot_all_off: assert property (|sense_in.over_temp |=> drv == '0)
    else $error("switch on while over temperature");
  chk_uv_all_off: assert property ((sense_in.undervoltage_lockout || sense_in.logic_uv)
    |=> drv == '0)
    else $error("switch on during undervoltage");
  chk_ov_lockout: assert property (|sense_in.overvoltage && ctl_out.overvoltage_lockout_ctl
    |=> drv == '0)
    else $error("switch on during overvoltage lockout");
  chk_only_selected: assert property ((drv & ~$past(ctl_out.sel)) == '0)
    else $error("switch on without selection");
  chk_oc_flag_set: assert property (|(sense_in.overcurrent & drv)
    |=> status_out.overload_flag)
    else $error("overload flag missed");
  chk_warn_flag_set: assert property (|sense_in.thermal_warn
    |=> status_out.thermal_warning_flag)
    else $error("thermal warning flag missed");
  chk_warn_flag_held: assert property ($fell(status_out.thermal_warning_flag)
    |-> ctl_out.status_clear_request || ctl_out == CTL_RST)
    else $error("thermal warning cleared without request");
  chk_select_shows_warn: assert property ($rose(sdo_oe_out)
    |-> sdo_out == $past(status_out.thermal_warning_flag))
    else $error("serial out not thermal warning at select");
endmodule // hbf_checker

bind hbf_top hbf_checker #(
  .UL_DELAY (UL_DELAY)
) i_chk (
  .mclk_in              (mclk_in),
  .rst_n_in             (rst_n_in),
  .enable_in            (enable_in),
  .chip_select_n_in     (chip_select_n_in),
  .sclk_in              (sclk_in),
  .sdi_in               (sdi_in),
  .sdo_out              (sdo_out),
  .sdo_oe_out           (sdo_oe_out),
  .sense_in             (sense_in),
  .low_side_output_out  (low_side_output_out),
  .high_side_output_out (high_side_output_out),
  .ctl_out              (ctl_out),
  .status_out           (status_out)
);

// File: hbf_host.sv
// Purpose: serial bus master standing in for the host controller
// Assumes: free-running timing, unrelated to mclk
// Notes:   clock and data rest low between frames
`timescale 1ns/1ps
module hbf_host (
  output logic      chip_select_n_out,
  output logic      sclk_out,
  output logic      sdi_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in
);
  initial
  begin
    chip_select_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end

  // 64 ns bit time, lsb first, data held over the falling edge
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    r = '0;
    chip_select_n_out = 1'b0;
    #32;
    for (int i = 0; i < n; i++)
    begin
      r[i] = sdo_oe_in ? sdo_in : 1'bx;
      sclk_out = 1'b1;
      sdi_out = w[i];
      #32;
      sclk_out = 1'b0;
      #32;
    end
    sdi_out = 1'b0;
    chip_select_n_out = 1'b1;
    #32;
  endtask
endmodule // hbf_host

// File: hbf_pkg.sv
// Purpose: shared constants and word layouts for the half-bridge fault control
// Assumes: 16-bit serial words, six half-bridge channels
// Notes:   bit positions follow the serial word layout, lsb first on the wire
package hbf_pkg;

  localparam int unsigned WORD_W       = 16;
  localparam int unsigned CHANNELS     = 6;
  localparam int unsigned SWITCHES     = 2 * CHANNELS;
  localparam int unsigned BITCNT_W     = 4;

  // input word field positions
  localparam int unsigned IN_CLEAR_BIT = 0;
  localparam int unsigned IN_SEL_LSB   = 1;
  localparam int unsigned IN_OC_SHUT_BIT = 13;
  localparam int unsigned IN_UL_SHUT_BIT = 14;
  localparam int unsigned IN_OV_LOCK_BIT = 15;

  // output word field positions
  localparam int unsigned OUT_WARN_BIT      = 0;
  localparam int unsigned OUT_ST_LSB        = 1;
  localparam int unsigned OUT_OVERLOAD_BIT  = 13;
  localparam int unsigned OUT_UNDERLOAD_BIT = 14;
  localparam int unsigned OUT_FAIL_BIT      = 15;

  // under-load delay in mclk cycles, plain default
  localparam int unsigned UL_DELAY_CYCLES = 200;
  localparam int unsigned UL_CNT_W        = 16;

  // synchroniser reset levels: chip select idles high, the rest low
  localparam logic [3:0] PIN_RST_VAL = 4'h2;

  // control word as shifted in, msb first in the struct
  typedef struct packed {
    logic                  overvoltage_lockout_ctl;
    logic                  underload_ctl_flag;
    logic                  overcurrent_shutdown_ctl;
    logic [SWITCHES-1:0]   sel;
    logic                  status_clear_request;
  } hbf_ctl_t;

  // status word as shifted out
  typedef struct packed {
    logic                  supply_fail_flag;
    logic                  underload_flag;
    logic                  overload_flag;
    logic [SWITCHES-1:0]   state;
    logic                  thermal_warning_flag;
  } hbf_stat_t;

  localparam hbf_ctl_t CTL_RST = '0;

  // comparator results from the analog side, already on mclk
  typedef struct packed {
    logic [1:0]            overvoltage;
    logic                  undervoltage_lockout;
    logic                  logic_uv;
    logic [SWITCHES-1:0]   overcurrent;
    logic [SWITCHES-1:0]   underload;
    logic [CHANNELS-1:0]   thermal_warn;
    logic [CHANNELS-1:0]   over_temp;
  } hbf_sense_t;

endpackage

// File: hbf_sync.sv
// Purpose: two-stage synchroniser for asynchronous pins
// Assumes: one mclk domain, synchronous active-low reset
// Notes:   only the second stage may be read outside this module
`timescale 1ns/1ps
module hbf_sync #(
  parameter int unsigned     W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic          mclk_in,
  input  wire logic          rst_n_in,
  input  wire logic [W-1:0]  d_in,
  output logic      [W-1:0]  q_out
);

  logic [W-1:0] meta;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      meta  <= RST_VAL;
      q_out <= RST_VAL;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule // hbf_sync

// File: hbf_top.sv
// Purpose: protection and output control of a six-channel half-bridge driver
// Assumes: mclk_in 200 MHz; rst_n_in low models logic-supply power-up
// Notes:   serial pins are sampled by mclk, so sclk must stay well below mclk/4
//
// What this block does
// - sleep low discards all programmed state
// - floating pins default: select high, others low
// - all switches start off until commanded
// - enabled output stays on unless undervoltage/command/fault
// - power-up reset; serial ignored during logic undervoltage
// - programmed state survives driver supply range
// - overcurrent with shutdown bit latches output off
// - any overcurrent on a driven switch sets sticky overload flag
// - no output turns on above thermal shutdown
// - long under-load sets sticky under-load flag
// - under-load shutdown bit latches offender off
// - overvoltage sets sticky supply-fail flag
// - overvoltage lockout bit forces outputs off
// - overvoltage keeps selection; outputs return afterwards
// - thermal warning sets flag, outputs stay on
// - any over-temperature turns all off, auto restore
// - thermal warning stays until status clear
// - serial out shows thermal warning at select fall
// - 16-bit words, lsb first, falling clock samples
// - accept only whole 16-bit multiples; out tristate
// - input word: clear, twelve switches, three controls
// - output word: fail flags, echoes, thermal warning
`timescale 1ns/1ps
module hbf_top
  import hbf_pkg::*;
#(
  parameter int unsigned UL_DELAY = hbf_pkg::UL_DELAY_CYCLES
) (
  input  wire logic                          mclk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          enable_in,
  input  wire logic                          chip_select_n_in,
  input  wire logic                          sclk_in,
  input  wire logic                          sdi_in,
  output logic                               sdo_out,
  output logic                               sdo_oe_out,
  input  wire hbf_pkg::hbf_sense_t           sense_in,
  output logic [hbf_pkg::CHANNELS-1:0]       low_side_output_out,
  output logic [hbf_pkg::CHANNELS-1:0]       high_side_output_out,
  output hbf_pkg::hbf_ctl_t                  ctl_out,
  output hbf_pkg::hbf_stat_t                 status_out
);

  import hbf_pkg::*;

  logic [3:0]           pins_sync;
  logic                 en_s;
  logic                 cs_n_s;
  logic                 sclk_s;
  logic                 sdi_s;
  logic                 cs_n_d;
  logic                 sclk_d;
  logic                 cs_fall;
  logic                 cs_rise;
  logic                 sclk_fall;
  logic                 active;
  logic                 clr_state;

  logic [WORD_W-1:0]    shreg;
  logic [BITCNT_W-1:0]  bitcnt;
  logic                 got_bits;
  logic                 frame_ok;
  logic                 do_clear;

  hbf_ctl_t             ctl;
  hbf_ctl_t             rx_word;
  logic [SWITCHES-1:0]  latch_off;
  logic [SWITCHES-1:0]  sw_on;
  logic [SWITCHES-1:0]  next_sw_on;
  logic                 global_off;
  logic                 ov_any;

  logic                 overload_flag;
  logic                 underload_flag;
  logic                 supply_fail_flag;
  logic                 thermal_warning_flag;

  logic [SWITCHES-1:0]  oc_evt;
  logic [SWITCHES-1:0]  ul_evt;
  logic [UL_CNT_W-1:0]  ul_cnt [SWITCHES];

  hbf_stat_t            stat_now;

  // pins cross into mclk; reset levels stand in for the pad pulls
  hbf_sync #(
    .W       (4),
    .RST_VAL (PIN_RST_VAL)
  ) u_pin_sync (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({enable_in, sdi_in, chip_select_n_in, sclk_in}),
    .q_out    (pins_sync)
  );

  assign en_s   = pins_sync[3];
  assign sdi_s  = pins_sync[2];
  assign cs_n_s = pins_sync[1];
  assign sclk_s = pins_sync[0];

  // sleep wipes everything power-up does except the pin syncs, cs_n_d and sclk_d
  assign clr_state = !rst_n_in || !en_s;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end
    else
    begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  // serial port ignored while asleep or logic supply is low
  assign active    = en_s && !sense_in.logic_uv;
  assign cs_fall   = cs_n_d && !cs_n_s && active;
  assign cs_rise   = !cs_n_d && cs_n_s;
  assign sclk_fall = sclk_d && !sclk_s && !cs_n_s && active;

  // status word presented to the host
  always_comb
  begin
    stat_now                      = '0;
    stat_now.supply_fail_flag     = supply_fail_flag;
    stat_now.underload_flag       = underload_flag;
    stat_now.overload_flag        = overload_flag;
    stat_now.state                = sw_on;
    stat_now.thermal_warning_flag = thermal_warning_flag;
  end

  assign status_out = stat_now;

  // one register shifts both ways, which also gives daisy chaining
  always_ff @(posedge mclk_in)
  begin
    if (clr_state)
    begin
      shreg <= '0;
    end
    else if (cs_fall)
    begin
      shreg <= stat_now;
    end
    else if (sclk_fall)
    begin
      shreg <= {sdi_s, shreg[WORD_W-1:1]};
    end
  end

  // lsb leaves first; drive only once the status load has landed, so the
  // first bit the host sees is always the thermal warning
  assign sdo_out    = shreg[0];
  assign sdo_oe_out = !cs_n_d && !cs_n_s && active;

  // bit counter modulo one word
  always_ff @(posedge mclk_in)
  begin
    if (clr_state || cs_fall)
    begin
      bitcnt   <= '0;
      got_bits <= 1'b0;
    end
    else if (sclk_fall)
    begin
      bitcnt   <= bitcnt + BITCNT_W'(1);
      got_bits <= 1'b1;
    end
  end

  // a partial word is thrown away on select rise
  assign frame_ok = cs_rise && got_bits && (bitcnt == '0) && active;
  assign rx_word  = hbf_ctl_t'(shreg);
  assign do_clear = frame_ok && rx_word.status_clear_request;

  // control word; survives driver-supply events, lost only on reset or sleep
  always_ff @(posedge mclk_in)
  begin
    if (clr_state)
    begin
      ctl <= CTL_RST;
    end
    else if (frame_ok)
    begin
      ctl <= rx_word;
    end
  end

  assign ctl_out = ctl;

  assign ov_any = |sense_in.overvoltage;

  // conditions that hold every switch off without touching selection
  assign global_off = sense_in.undervoltage_lockout
                   || sense_in.logic_uv
                   || (ov_any && ctl.overvoltage_lockout_ctl)
                   || (|sense_in.over_temp);

  // per-switch overcurrent is only meaningful while driven
  assign oc_evt = sense_in.overcurrent & sw_on;

  // under-load must persist for the delay before it counts
  genvar gi;
  generate
    for (gi = 0; gi < SWITCHES; gi++)
    begin : g_ul
      always_ff @(posedge mclk_in)
      begin
        if (clr_state || !sw_on[gi] || !sense_in.underload[gi])
        begin
          ul_cnt[gi] <= '0;
        end
        else if (ul_cnt[gi] < UL_CNT_W'(UL_DELAY))
        begin
          ul_cnt[gi] <= ul_cnt[gi] + UL_CNT_W'(1);
        end
      end
      assign ul_evt[gi] = (ul_cnt[gi] >= UL_CNT_W'(UL_DELAY));
    end
  endgenerate

  // latched-off switches; new events beat a clear in the same cycle
  always_ff @(posedge mclk_in)
  begin
    if (clr_state)
    begin
      latch_off <= '0;
    end
    else
    begin
      latch_off <= (do_clear ? '0 : latch_off)
                 | (ctl.overcurrent_shutdown_ctl ? oc_evt : '0)
                 | (ctl.underload_ctl_flag ? ul_evt : '0);
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge mclk_in)
  begin
    if (clr_state)
    begin
      overload_flag <= 1'b0;
    end
    else if (|oc_evt)
    begin
      overload_flag <= 1'b1;
    end
    else if (do_clear)
    begin
      overload_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (clr_state)
    begin
      underload_flag <= 1'b0;
    end
    else if (|ul_evt)
    begin
      underload_flag <= 1'b1;
    end
    else if (do_clear)
    begin
      underload_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (clr_state)
    begin
      supply_fail_flag <= 1'b0;
    end
    else if (ov_any || sense_in.undervoltage_lockout)
    begin
      supply_fail_flag <= 1'b1;
    end
    else if (do_clear)
    begin
      supply_fail_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (clr_state)
    begin
      thermal_warning_flag <= 1'b0;
    end
    else if (|sense_in.thermal_warn)
    begin
      thermal_warning_flag <= 1'b1;
    end
    else if (do_clear)
    begin
      thermal_warning_flag <= 1'b0;
    end
  end

  // switch drive; cleared latches let the new selection take effect at once
  always_comb
  begin
    next_sw_on = '0;
    if (!global_off)
    begin
      next_sw_on = ctl.sel & ~latch_off;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (clr_state)
    begin
      sw_on <= '0;
    end
    else
    begin
      sw_on <= next_sw_on;
    end
  end

  // even selection bits are low side, odd are high side; no shoot-through
  // interlock here, the host owns leg pairing
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_drv
      assign low_side_output_out[gi]  = sw_on[2*gi];
      assign high_side_output_out[gi] = sw_on[2*gi+1];
    end
  endgenerate

endmodule // hbf_top

// File: test_half_bridge_fault_control.sv
// Purpose: directed test of the half-bridge fault control
// Assumes: host model drives the serial pins
// Notes:   under-load delay cut to 8 cycles; no word enables both sides of a leg
`timescale 1ns/1ps
module test_half_bridge_fault_control;
  import hbf_pkg::*;
  logic       mclk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       enable_in = 1'b1;
  logic       chip_select_n_in;
  logic       sclk_in;
  logic       sdi_in;
  logic       sdo_out;
  logic       sdo_oe_out;
  hbf_sense_t sense_in = '0;
  logic [5:0] low_side_output_out;
  logic [5:0] high_side_output_out;
  hbf_ctl_t   ctl_out;
  hbf_stat_t  status_out;
  logic [31:0] rd;
  int         err_total = 0;
  int         num_checks = 0;
  wire [11:0] outs = {low_side_output_out, high_side_output_out};

  always #2.5 mclk_in = ~mclk_in;

  hbf_host i_host (.chip_select_n_out(chip_select_n_in), .sclk_out(sclk_in),
    .sdi_out(sdi_in), .sdo_in(sdo_out), .sdo_oe_in(sdo_oe_out));
  hbf_top #(
    .UL_DELAY (8)
  ) i_dut (
    .mclk_in              (mclk_in),
    .rst_n_in             (rst_n_in),
    .enable_in            (enable_in),
    .chip_select_n_in     (chip_select_n_in),
    .sclk_in              (sclk_in),
    .sdi_in               (sdi_in),
    .sdo_out              (sdo_out),
    .sdo_oe_out           (sdo_oe_out),
    .sense_in             (sense_in),
    .low_side_output_out  (low_side_output_out),
    .high_side_output_out (high_side_output_out),
    .ctl_out              (ctl_out),
    .status_out           (status_out)
  );

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] w);
    i_host.xfer({16'h0, w}, 16, rd);
    step(12);
  endtask

  task print_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_total++;
    print_verdict;
  end

  initial
  begin
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    step(6);
    chk(outs, 0);
    wr(16'h1332);
    chk(ctl_out, 16'h1332);
    chk(outs, 12'h56A);
    @(posedge mclk_in) sense_in.undervoltage_lockout <= 1'b1;
    step(3);
    chk(outs, 0);
    @(posedge mclk_in) sense_in.undervoltage_lockout <= 1'b0;
    step(3);
    chk(ctl_out, 16'h1332);
    // logic supply low: serial traffic ignored, switches held off
    @(posedge mclk_in) sense_in.logic_uv <= 1'b1;
    step(3);
    wr(16'h0000);
    chk(ctl_out, 16'h1332);
    chk(outs, 0);
    @(posedge mclk_in) sense_in.logic_uv <= 1'b0;
    step(3);
    chk(outs, 12'h56A);
    i_host.xfer(32'h1332C0DE, 32, rd);
    step(12);
    chk(rd[31:16], 16'hC0DE);
    chk(rd[12:0], 13'h1332);
    i_host.xfer(32'h0, 15, rd);
    step(12);
    chk(ctl_out, 16'h1332);
    // overcurrent pulse on the first low side, shutdown off then on
    @(posedge mclk_in) sense_in.overcurrent <= 12'h001;
    step(2);
    @(posedge mclk_in) sense_in.overcurrent <= '0;
    step(3);
    chk(outs, 12'h56A);
    chk(status_out.overload_flag, 1);
    wr(16'h3333);
    chk(status_out[15:13], 0);
    @(posedge mclk_in) sense_in.overcurrent <= 12'h001;
    step(2);
    @(posedge mclk_in) sense_in.overcurrent <= '0;
    step(3);
    chk(outs, 12'h52A);
    wr(16'h3333);
    chk(outs, 12'h56A);
    @(posedge mclk_in) sense_in.overvoltage <= 2'b01;
    step(3);
    chk(outs, 12'h56A);
    wr(16'hB333);
    chk(outs, 0);
    chk(status_out.supply_fail_flag, 1);
    @(posedge mclk_in) sense_in.overvoltage <= 2'b00;
    step(3);
    chk(outs, 12'h56A);
    @(posedge mclk_in) sense_in.thermal_warn <= 6'h04;
    step(3);
    chk(outs, 12'h56A);
    @(posedge mclk_in) sense_in.over_temp <= 6'h20;
    step(3);
    chk(outs, 0);
    wr(16'hB332);
    chk(outs, 0);
    @(posedge mclk_in) sense_in.over_temp <= '0;
    sense_in.thermal_warn <= '0;
    step(3);
    chk(outs, 12'h56A);
    chk(status_out.thermal_warning_flag, 1);
    i_host.xfer(32'hB332, 16, rd);
    step(12);
    chk(rd[0], 1);
    wr(16'hB333);
    chk(status_out.thermal_warning_flag, 0);
    wr(16'h5333);
    @(posedge mclk_in) sense_in.underload <= 12'h008;
    step(12);
    @(posedge mclk_in) sense_in.underload <= '0;
    step(3);
    chk(status_out.underload_flag, 1);
    chk(outs, 12'h568);
    @(posedge mclk_in) enable_in <= 1'b0;
    step(6);
    @(posedge mclk_in) enable_in <= 1'b1;
    step(6);
    chk({ctl_out, outs}, 0);
    print_verdict;
  end
endmodule // test_half_bridge_fault_control
